// >>> spv_regs.vh
// Constants of the serial program/verify port
`ifndef SPV_REGS_VH
`define SPV_REGS_VH

`define SPV_CMD_LOAD_CFG 6'h00
`define SPV_CMD_LOAD_DATA 6'h02
`define SPV_CMD_READ_DATA 6'h04
`define SPV_CMD_INC_ADDR 6'h06
`define SPV_CMD_BEGIN_PROG 6'h08
`define SPV_CMD_END_PROG 6'h0e

`define SPV_CMD_LAST_BIT 5'h05
`define SPV_DATA_FIRST_EDGE 5'h01
`define SPV_DATA_LAST_EDGE 5'h0e
`define SPV_STOP_EDGE 5'h0f
`define SPV_FRAME_EDGES 5'h10

`define SPV_PC_RESET 14'h0000
`define SPV_CFG_BASE 14'h2000
`define SPV_USER_TOP 14'h1fff
`define SPV_ID_FIRST 14'h2000
`define SPV_ID_LAST 14'h2003
`define SPV_CFG_WORD 14'h2007
`define SPV_CFG_AW 3

`endif

// >>> spv_fifo.v
// Word FIFO with valid/ready on both sides
`default_nettype none
module spv_fifo #(
  parameter WIDTH = 28,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire mclk,
  input wire rst,
  input wire inValid,
  output wire inReady,
  input wire [WIDTH-1:0] inData,
  output wire outValid,
  input wire outReady,
  output wire [WIDTH-1:0] outData
);
  localparam [AW:0] FULL_COUNT = DEPTH[AW:0];
  reg [WIDTH-1:0] store [0:DEPTH-1];
  reg [AW-1:0] wrPtr_ff;
  reg [AW-1:0] rdPtr_ff;
  reg [AW:0] count_ff;
  wire doPush;
  wire doPop;

  assign inReady = (count_ff != FULL_COUNT);
  assign outValid = (count_ff != {(AW+1){1'b0}});
  assign outData = store[rdPtr_ff];
  assign doPush = inValid & inReady;
  assign doPop = outValid & outReady;

  always @(posedge mclk) begin
    if (doPush) begin
      store[wrPtr_ff] <= inData;
    end
  end

  always @(posedge mclk) begin
    if (rst) begin
      wrPtr_ff <= {AW{1'b0}};
      rdPtr_ff <= {AW{1'b0}};
      count_ff <= {(AW+1){1'b0}};
    end else begin
      if (doPush) begin
        wrPtr_ff <= wrPtr_ff + {{(AW-1){1'b0}}, 1'b1};
      end
      if (doPop) begin
        rdPtr_ff <= rdPtr_ff + {{(AW-1){1'b0}}, 1'b1};
      end
      if (doPush && !doPop) begin
        count_ff <= count_ff + {{AW{1'b0}}, 1'b1};
      end else if (doPop && !doPush) begin
        count_ff <= count_ff - {{AW{1'b0}}, 1'b1};
      end
    end
  end
endmodule
`default_nettype wire

// >>> spv_mem.v
// User program and configuration word store
`include "spv_regs.vh"
`default_nettype none
module spv_mem #(
  parameter USER_AW = 13
) (
  input wire mclk,
  input wire rst,
  input wire wrEn,
  input wire [13:0] wrAddr,
  input wire [13:0] wrData,
  input wire [13:0] rdAddr,
  output reg [13:0] rdData_ff
);
  localparam CFG_WORDS = 1 << `SPV_CFG_AW;
  reg [13:0] userMem [0:(1<<USER_AW)-1];
  reg [13:0] cfgMem [0:CFG_WORDS-1];
  wire wrCfgOk;
  wire rdCfgOk;

  // Only 0x2000..0x2007 exist in configuration space; the rest is reserved
  assign wrCfgOk = (wrAddr[12:`SPV_CFG_AW] == {(13-`SPV_CFG_AW){1'b0}});
  assign rdCfgOk = (rdAddr[12:`SPV_CFG_AW] == {(13-`SPV_CFG_AW){1'b0}});

  always @(posedge mclk) begin
    if (wrEn && wrAddr[13] && wrCfgOk) begin
      cfgMem[wrAddr[`SPV_CFG_AW-1:0]] <= wrData;
    end
    if (wrEn && !wrAddr[13]) begin
      userMem[wrAddr[USER_AW-1:0]] <= wrData;
    end
  end

  always @(posedge mclk) begin
    if (rst) begin
      rdData_ff <= 14'h0000;
    end else if (rdAddr[13]) begin
      rdData_ff <= rdCfgOk ? cfgMem[rdAddr[`SPV_CFG_AW-1:0]] : 14'h0000;
    end else begin
      rdData_ff <= userMem[rdAddr[USER_AW-1:0]];
    end
  end
endmodule
`default_nettype wire

// >>> spv_port.v
// Serial program/verify port: entry, command shifter, frames, program counter
// Operation
// - Entry holds other logic reset, starts user
// - Six command bits, falling edge, LSb first
// - Frame: start, 14 data bits, stop
// - Read drives LSb at second rising edge
// - Load captures LSb at second falling edge
// - Load-configuration sets counter to 0x2000
// - Counter top bit sticks until master clear drops
// - User counter wraps inside implemented memory
// - User space 0x0000-0x1FFF, partly implemented
// - ID words at 0x2000-0x2003
// - Mode reaches user, ID, configuration words
// - Read drives pin from rise 2 to 16
// - Increment command advances counter by one
// - Configuration word sits at 0x2007
`include "spv_regs.vh"
`default_nettype none
module spv_port #(
  parameter USER_AW = 13,
  parameter FIFO_DEPTH = 16,
  parameter FIFO_AW = 4
) (
  input wire mclk,
  input wire rst,
  input wire serialClockPin,
  input wire serialDataPinIn,
  output reg serialDataPinOut_ff,
  output reg serialDataPinOe_n_ff,
  input wire masterClearHvPin,
  output reg progMode_ff,
  output reg progPulse_ff,
  output reg [13:0] pc_ff,
  output reg loadDropped_ff
);
  localparam [3:0] ST_OFF = 4'b0001;
  localparam [3:0] ST_CMD = 4'b0010;
  localparam [3:0] ST_LOAD = 4'b0100;
  localparam [3:0] ST_READ = 4'b1000;
  // Mask of the implemented user words, 13 bits wide like the counter below its top bit
  localparam [12:0] USER_MASK = ~(13'h1fff << USER_AW);

  reg [2:0] syncA_ff;
  reg [2:0] syncB_ff;
  reg [2:0] prev_ff;
  reg [3:0] state_ff;
  reg [4:0] bitCnt_ff;
  reg [5:0] cmd_ff;
  reg [13:0] shift_ff;
  reg [3:0] nxt_state;
  reg [4:0] nxt_bitCnt;
  reg [5:0] nxt_cmd;
  reg [13:0] nxt_shift;
  reg [13:0] nxt_pc;
  reg nxt_progMode;
  reg nxt_progPulse;
  reg nxt_loadDropped;
  reg nxt_dataOut;
  reg nxt_dataOe_n;
  reg fifoPush;
  reg fifoPop;
  reg memWr;
  reg [5:0] cmdNew;
  wire sclk;
  wire sdat;
  wire hv;
  wire sclkRise;
  wire sclkFall;
  wire hvRise;
  wire fifoInReady;
  wire fifoOutValid;
  wire [27:0] fifoOutData;
  wire [13:0] memRdData;

  // Advance the counter; configuration space keeps its top bit
  function [13:0] pcInc;
    input [13:0] p;
    reg [12:0] low;
    begin
      low = p[12:0] + 13'h0001;
      if (p[13]) begin
        pcInc = {1'b1, low};
      end else begin
        pcInc = {1'b0, low & USER_MASK};
      end
    end
  endfunction

  // True for the frame clocks that carry data bits, between start and stop
  function dataSlot;
    input [4:0] n;
    begin
      dataSlot = (n >= `SPV_DATA_FIRST_EDGE) && (n <= `SPV_DATA_LAST_EDGE);
    end
  endfunction

  // True on the sixteenth clock of a frame
  function stopSlot;
    input [4:0] n;
    begin
      stopSlot = (n == `SPV_STOP_EDGE);
    end
  endfunction

  assign sclk = syncB_ff[0];
  assign sdat = syncB_ff[1];
  assign hv = syncB_ff[2];
  assign sclkRise = sclk & ~prev_ff[0];
  assign sclkFall = ~sclk & prev_ff[0];
  assign hvRise = hv & ~prev_ff[2];

  // Loaded words wait here, tagged with their address, until programmed
  spv_fifo #(
    .WIDTH(28),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .mclk(mclk),
    .rst(rst),
    .inValid(fifoPush),
    .inReady(fifoInReady),
    .inData({pc_ff, shift_ff}),
    .outValid(fifoOutValid),
    .outReady(fifoPop),
    .outData(fifoOutData)
  );

  // User words, ID words and configuration word
  spv_mem #(
    .USER_AW(USER_AW)
  ) u_mem (
    .mclk(mclk),
    .rst(rst),
    .wrEn(memWr),
    .wrAddr(fifoOutData[27:14]),
    .wrData(fifoOutData[13:0]),
    .rdAddr(pc_ff),
    .rdData_ff(memRdData)
  );

  always @* begin
    nxt_state = state_ff;
    nxt_bitCnt = bitCnt_ff;
    nxt_cmd = cmd_ff;
    nxt_shift = shift_ff;
    nxt_pc = pc_ff;
    nxt_progMode = progMode_ff;
    nxt_progPulse = progPulse_ff;
    nxt_loadDropped = loadDropped_ff;
    nxt_dataOut = serialDataPinOut_ff;
    nxt_dataOe_n = serialDataPinOe_n_ff;
    fifoPush = 1'b0;
    fifoPop = 1'b0;
    memWr = 1'b0;
    cmdNew = {sdat, cmd_ff[5:1]};
    case (state_ff)
      // Idle until the high-voltage entry sequence
      ST_OFF: begin
        nxt_dataOe_n = 1'b1;
        // Words left from an earlier session are dropped, never written
        fifoPop = fifoOutValid;
        if (hvRise && !sclk && !sdat) begin
          nxt_state = ST_CMD;
          nxt_progMode = 1'b1;
          nxt_pc = `SPV_PC_RESET;
          nxt_bitCnt = 5'h00;
          nxt_cmd = 6'h00;
          nxt_shift = 14'h0000;
        end
      end
      // Six falling clock edges shift a command in
      ST_CMD: begin
        if (sclkFall) begin
          nxt_cmd = cmdNew;
          nxt_bitCnt = bitCnt_ff + 5'h01;
          if (bitCnt_ff == `SPV_CMD_LAST_BIT) begin
            nxt_bitCnt = 5'h00;
            case (cmdNew)
              `SPV_CMD_LOAD_CFG: begin
                nxt_pc = `SPV_CFG_BASE;
                nxt_state = ST_LOAD;
              end
              `SPV_CMD_LOAD_DATA: begin
                nxt_state = ST_LOAD;
              end
              `SPV_CMD_READ_DATA: begin
                nxt_shift = memRdData;
                nxt_state = ST_READ;
              end
              `SPV_CMD_INC_ADDR: begin
                nxt_pc = pcInc(pc_ff);
              end
              `SPV_CMD_BEGIN_PROG: begin
                fifoPop = fifoOutValid;
                memWr = fifoOutValid;
                nxt_progPulse = 1'b1;
              end
              `SPV_CMD_END_PROG: begin
                nxt_progPulse = 1'b0;
              end
              default: begin
                nxt_state = ST_CMD;
              end
            endcase
          end
        end
      end
      // Load frame: data bits taken on falling edges
      ST_LOAD: begin
        if (sclkFall) begin
          nxt_bitCnt = bitCnt_ff + 5'h01;
          if (dataSlot(bitCnt_ff)) begin
            nxt_shift = {sdat, shift_ff[13:1]};
          end
          if (stopSlot(bitCnt_ff)) begin
            fifoPush = 1'b1;
            nxt_loadDropped = loadDropped_ff | ~fifoInReady;
            nxt_bitCnt = 5'h00;
            nxt_state = ST_CMD;
          end
        end
      end
      // Read frame: data bits driven on rising edges
      ST_READ: begin
        if (sclkRise) begin
          nxt_bitCnt = bitCnt_ff + 5'h01;
          if (dataSlot(bitCnt_ff)) begin
            nxt_dataOe_n = 1'b0;
            nxt_dataOut = shift_ff[0];
            nxt_shift = {1'b0, shift_ff[13:1]};
          end
          if (stopSlot(bitCnt_ff)) begin
            nxt_dataOe_n = 1'b1;
            nxt_dataOut = 1'b0;
          end
        end
        if (sclkFall && bitCnt_ff == `SPV_FRAME_EDGES) begin
          nxt_bitCnt = 5'h00;
          nxt_state = ST_CMD;
        end
      end
      default: begin
        nxt_state = ST_OFF;
      end
    endcase
    // Dropping master clear leaves the mode and sets the counter back to user address 0x0000
    if (!hv && state_ff != ST_OFF) begin
      nxt_state = ST_OFF;
      nxt_progMode = 1'b0;
      nxt_progPulse = 1'b0;
      nxt_pc = `SPV_PC_RESET;
      nxt_dataOe_n = 1'b1;
      nxt_dataOut = 1'b0;
      nxt_bitCnt = 5'h00;
      nxt_cmd = 6'h00;
      nxt_shift = 14'h0000;
    end
  end

  // Two-flop synchronisers on the pins, then one stage for edge detection
  always @(posedge mclk) begin
    if (rst) begin
      syncA_ff <= 3'h0;
      syncB_ff <= 3'h0;
      prev_ff <= 3'h0;
    end else begin
      syncA_ff <= {masterClearHvPin, serialDataPinIn, serialClockPin};
      syncB_ff <= syncA_ff;
      prev_ff <= syncB_ff;
    end
  end

  always @(posedge mclk) begin
    if (rst) begin
      state_ff <= ST_OFF;
      bitCnt_ff <= 5'h00;
      cmd_ff <= 6'h00;
      shift_ff <= 14'h0000;
      pc_ff <= `SPV_PC_RESET;
      progMode_ff <= 1'b0;
      progPulse_ff <= 1'b0;
      loadDropped_ff <= 1'b0;
      serialDataPinOut_ff <= 1'b0;
      serialDataPinOe_n_ff <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      bitCnt_ff <= nxt_bitCnt;
      cmd_ff <= nxt_cmd;
      shift_ff <= nxt_shift;
      pc_ff <= nxt_pc;
      progMode_ff <= nxt_progMode;
      progPulse_ff <= nxt_progPulse;
      loadDropped_ff <= nxt_loadDropped;
      serialDataPinOut_ff <= nxt_dataOut;
      serialDataPinOe_n_ff <= nxt_dataOe_n;
    end
  end
endmodule
`default_nettype wire

// >>> spv_port_checker.sv
// Assertions on the program/verify port pins and counter
`default_nettype none
module spv_port_checker #(
  parameter USER_AW = 13
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic serialClockPin,
  input wire logic serialDataPinIn,
  input wire logic serialDataPinOut_ff,
  input wire logic serialDataPinOe_n_ff,
  input wire logic masterClearHvPin,
  input wire logic progMode_ff,
  input wire logic progPulse_ff,
  input wire logic [13:0] pc_ff,
  input wire logic loadDropped_ff
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [13:0] UMASK = (14'h1 << USER_AW) - 14'h1;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  a_idle_released: assert property (!progMode_ff |-> serialDataPinOe_n_ff)
    else $error("idle drive");
  a_idle_pc_zero: assert property (!progMode_ff |-> pc_ff == 14'h0)
    else $error("idle pc");
  a_pc_one_step: assert property (progMode_ff && $past(progMode_ff) && pc_ff != $past(pc_ff)
    |-> pc_ff == 14'h2000 || (pc_ff[13] ? pc_ff[12:0] == $past(pc_ff[12:0]) + 13'h1
    : pc_ff == (($past(pc_ff) + 14'h1) & UMASK)))
    else $error("pc step");
  a_top_bit_sticks: assert property (progMode_ff && $past(pc_ff[13]) |-> pc_ff[13])
    else $error("pc top bit");
  a_cfg_base_entry: assert property ($rose(pc_ff[13]) |-> pc_ff == 14'h2000)
    else $error("cfg base");
  a_exit_bounded: assert property (!masterClearHvPin [*4] |-> !progMode_ff)
    else $error("exit late");
  a_pulse_in_mode: assert property (progPulse_ff |-> progMode_ff)
    else $error("pulse idle");
  a_drive_on_rise: assert property ($fell(serialDataPinOe_n_ff) |-> serialClockPin)
    else $error("drive start");
  a_release_on_rise: assert property ($rose(serialDataPinOe_n_ff) && progMode_ff |-> serialClockPin)
    else $error("release");
  a_bit_on_rise: assert property (!serialDataPinOe_n_ff && $changed(serialDataPinOut_ff)
    |-> serialClockPin)
    else $error("bit timing");
endmodule
bind spv_port spv_port_checker #(.USER_AW(USER_AW)) u_spv_port_checker (.mclk(mclk), .rst(rst),
  .serialClockPin(serialClockPin), .serialDataPinIn(serialDataPinIn),
  .serialDataPinOut_ff(serialDataPinOut_ff), .serialDataPinOe_n_ff(serialDataPinOe_n_ff),
  .masterClearHvPin(masterClearHvPin), .progMode_ff(progMode_ff), .progPulse_ff(progPulse_ff),
  .pc_ff(pc_ff), .loadDropped_ff(loadDropped_ff));
`default_nettype wire

// >>> spv_prog.sv
// Programmer model driving the link clock, data pin and high-voltage clear
`default_nettype none
module spv_prog (
  input wire logic mclk,
  input wire logic dataLine,
  output logic sclk,
  output logic sdat,
  output logic mclrHv
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    sclk = 1'b0;
    sdat = 1'b0;
    mclrHv = 1'b0;
  end
  // Half period of the 400 ns link clock
  task automatic step(input logic c, input logic d);
    repeat (4) @(posedge mclk);
    #1;
    sclk = c;
    sdat = d;
  endtask
  task automatic enter(input logic clkHigh);
    repeat (5) @(posedge mclk);
    #1;
    sclk = clkHigh;
    sdat = 1'b0;
    mclrHv = 1'b1;
    repeat (10) @(posedge mclk);
    #1;
    sclk = 1'b0;
  endtask
  task automatic leave();
    @(posedge mclk);
    #1;
    mclrHv = 1'b0;
    repeat (10) @(posedge mclk);
  endtask
  task automatic cmd(input logic [5:0] k);
    for (int i = 0; i < 6; i++) begin
      step(1'b1, k[i]);
      step(1'b0, k[i]);
    end
    repeat (20) @(posedge mclk);
  endtask
  // Reads leave the line to the device and toggle the released drive
  task automatic frame(input logic [13:0] w, input logic rd, output logic [13:0] got);
    logic d;
    for (int i = 0; i < 16; i++) begin
      d = (i > 0 && i < 15) ? w[i-1] : 1'b0;
      step(1'b1, rd ? i[0] : d);
      repeat (4) @(posedge mclk);
      #1;
      if (i > 0 && i < 15) got[i-1] = dataLine;
      sclk = 1'b0;
    end
    repeat (20) @(posedge mclk);
  endtask
endmodule
`default_nettype wire

// >>> tb_spv_port.sv
// Testbench for the serial program/verify port
`default_nettype none
module tb_spv_port;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic sclk, sdat, mclrHv, devOut, oeN, progMode, progPulse, dropped;
  logic [13:0] pc, got;
  wire dataLine;
  int fails = 0;
  int totalChecks = 0;
  assign dataLine = oeN ? sdat : devOut;
  always #25 mclk = ~mclk;
  spv_port #(.USER_AW(4)) u_spv_port (.mclk(mclk), .rst(rst),
    .serialClockPin(sclk), .serialDataPinIn(dataLine), .serialDataPinOut_ff(devOut),
    .serialDataPinOe_n_ff(oeN), .masterClearHvPin(mclrHv), .progMode_ff(progMode),
    .progPulse_ff(progPulse), .pc_ff(pc), .loadDropped_ff(dropped));
  spv_prog u_spv_prog (.mclk(mclk), .dataLine(dataLine), .sclk(sclk), .sdat(sdat),
    .mclrHv(mclrHv));
  task automatic check(input logic [13:0] g, input logic [13:0] e);
    totalChecks++;
    if (g !== e) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic cmd(input logic [5:0] k);
    u_spv_prog.cmd(k);
  endtask
  task automatic frm(input logic [13:0] w, input logic rd);
    u_spv_prog.frame(w, rd, got);
  endtask
  task automatic prog();
    cmd(6'h08);
    check(14'(progPulse), 14'h1);
    cmd(6'h0e);
    check(14'(progPulse), 14'h0);
  endtask
  task automatic t_entry();
    u_spv_prog.enter(1'b1);
    check(14'(progMode), 14'h0);
    u_spv_prog.leave();
    u_spv_prog.enter(1'b0);
    check({oeN, progMode, pc[11:0]}, 14'h3000);
    $display("entry done");
  endtask
  task automatic t_user();
    cmd(6'h02);
    frm(14'h2a5c, 1'b0);
    check(14'(dropped), 14'h0);
    prog();
    cmd(6'h04);
    frm(14'h0, 1'b1);
    check(got, 14'h2a5c);
    check(14'(oeN), 14'h1);
    $display("user load read done");
  endtask
  task automatic t_unknown();
    logic [5:0] codes[3] = '{6'h3f, 6'h01, 6'h0a};
    foreach (codes[i]) begin
      cmd(codes[i]);
      check(pc, 14'h0);
    end
    $display("unknown done");
  endtask
  task automatic t_wrap();
    for (int i = 1; i <= 16; i++) begin
      cmd(6'h06);
      check(pc, 14'(i & 15));
    end
    $display("wrap done");
  endtask
  task automatic t_config();
    cmd(6'h00);
    frm(14'h3ff5, 1'b0);
    check(pc, 14'h2000);
    prog();
    repeat (7) cmd(6'h06);
    check(pc, 14'h2007);
    cmd(6'h02);
    frm(14'h3f3f, 1'b0);
    prog();
    cmd(6'h04);
    frm(14'h0, 1'b1);
    check(got, 14'h3f3f);
    cmd(6'h00);
    frm(14'h0, 1'b0);
    cmd(6'h04);
    frm(14'h0, 1'b1);
    check(got, 14'h3ff5);
    repeat (16) cmd(6'h06);
    check(pc, 14'h2010);
    $display("config done");
  endtask
  task automatic t_buffer();
    u_spv_prog.leave();
    u_spv_prog.enter(1'b0);
    check(pc, 14'h0);
    for (int i = 0; i < 16; i++) begin
      cmd(6'h02);
      frm(14'(i), 1'b0);
    end
    check(14'(dropped), 14'h0);
    cmd(6'h02);
    frm(14'h0010, 1'b0);
    check(14'(dropped), 14'h1);
    repeat (18) prog();
    check(14'(dropped), 14'h1);
    cmd(6'h04);
    frm(14'h0, 1'b1);
    check(got, 14'h000f);
    $display("buffer done");
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", totalChecks, fails);
    if (fails == 0 && totalChecks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge mclk);
    #1;
    rst = 1'b0;
    t_entry();
    t_user();
    t_unknown();
    t_wrap();
    t_config();
    t_buffer();
    final_report();
  end
  initial begin
    repeat (100000) @(posedge mclk);
    fails++;
    final_report();
  end
endmodule
`default_nettype wire
